// *** core/i2ccs_pkg.sv ***
package i2ccs_pkg;
    // ---------------------------------------------------------------
    // register map (byte addresses, word aligned)
    // ---------------------------------------------------------------
    localparam logic [31:0] CONTROL_SET_OFFS   = 32'h400a_1000;
    localparam logic [31:0] CONTROL_CLEAR_OFFS = 32'h400a_1018;
    localparam logic [31:0] IRQ_STATUS_OFFS    = 32'h400a_1100;
    localparam logic [31:0] IRQ_ENABLE_OFFS    = 32'h400a_1104;
    localparam logic [31:0] IRQ_CLEAR_OFFS     = 32'h400a_1108;

    // ---------------------------------------------------------------
    // control bit positions and reset values
    // ---------------------------------------------------------------
    localparam int ACK_BIT   = 2;
    localparam int IFLAG_BIT = 3;
    localparam int STOP_BIT  = 4;
    localparam int START_BIT = 5;
    localparam int EN_BIT    = 6;
    localparam logic [4:0] CTRL_RESET = 5'h00;

    // interrupt status bit positions
    localparam int EV_START = 0;
    localparam int EV_STOP  = 1;
    localparam int EV_IFLAG = 2;
    localparam logic [2:0] IRQ_RESET = 3'h0;

    // control bits carried together
    typedef struct packed {
        logic enable;
        logic start;
        logic stop;
        logic iflag;
        logic ack;
    } i2ccs_ctrl_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } i2ccs_bus_t;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_START  = 2'b01,
        ST_MASTER = 2'b11,
        ST_STOP   = 2'b10
    } i2ccs_state_t;
endpackage

// *** core/i2ccs_top.sv ***
// Our own choice: strobed register access.
`timescale 1ns/100ps
// Contract
// (R1) writing one to a control set bit sets it; zero leaves it unchanged
// (R2) ack bit 2, flag 3, stop 4, start 5, enable 6; 3..6 reset zero
// (R3) software writes zeros to reserved bits; their read value is undefined
// (R4) enable bit turns the interface on; enable-clear write resets it
// (R5) while disabled: ignore bus inputs, stay unaddressed, stop held zero
// (R6) software should release the bus with the ack flag, not enable
// (R7) start request enters master and sends start, or repeated start
// (R8) reading control set returns the current implemented control bits
module i2ccs_top
    import i2ccs_pkg::*;
(
    input  wire logic        REF_CLK,
    input  wire logic        RESET_N,
    input  wire logic        CLK_EN,
    input  wire logic [31:0] ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [31:0] RDATA,
    input  wire logic        SCL_IN,
    input  wire logic        SDA_IN,
    output logic             SCL_OE_N,
    output logic             SDA_OE_N,
    output logic             MASTER,
    output logic             ADDRESSED,
    output logic             IRQ
);
    import i2ccs_pkg::*;

    // ---------------------------------------------------------------
    // bus capture
    // ---------------------------------------------------------------
    i2ccs_bus_t  bus;
    i2ccs_ctrl_t ctrl_q;
    i2ccs_ctrl_t ctrl_d;
    i2ccs_state_t state_q;
    logic [2:0]  irq_stat_q;
    logic [2:0]  irq_en_q;
    logic [1:0]  scl_sync_q;
    logic [1:0]  sda_sync_q;
    logic        scl_prev_q;
    logic        sda_prev_q;
    logic        wr_set;
    logic        wr_clr;
    logic        bus_start;
    logic        bus_stop;
    logic        start_ev;
    logic        stop_ev;

    assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
    assign wr_set = bus.wr && bus.addr == CONTROL_SET_OFFS;
    assign wr_clr = bus.wr && bus.addr == CONTROL_CLEAR_OFFS;

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    // two stages each; only stage two feeds edge logic
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else if (CLK_EN) begin
            scl_sync_q <= {scl_sync_q[0], SCL_IN};
            sda_sync_q <= {sda_sync_q[0], SDA_IN};
            scl_prev_q <= scl_sync_q[1];
            sda_prev_q <= sda_sync_q[1];
        end
    end

    // bus conditions seen only while enabled; inputs ignored otherwise
    // clock must be high on both sides of the data edge, so a data edge that
    // races a clock edge through the synchronisers is not taken as a condition
    assign bus_start = ctrl_q.enable && scl_prev_q && scl_sync_q[1] &&
                       sda_prev_q && !sda_sync_q[1]; // [R5]
    assign bus_stop  = ctrl_q.enable && scl_prev_q && scl_sync_q[1] &&
                       !sda_prev_q && sda_sync_q[1]; // [R5]

    // ---------------------------------------------------------------
    // control register
    // ---------------------------------------------------------------
    // next value: clear writes knock bits out, events set, set writes OR in ones
    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_clr) begin
            ctrl_d.ack    = ctrl_d.ack    & ~bus.wdata[ACK_BIT];
            ctrl_d.iflag  = ctrl_d.iflag  & ~bus.wdata[IFLAG_BIT];
            ctrl_d.start  = ctrl_d.start  & ~bus.wdata[START_BIT];
            ctrl_d.enable = ctrl_d.enable & ~bus.wdata[EN_BIT]; // [R4]
        end
        if (start_ev || stop_ev) begin
            ctrl_d.iflag = 1'b1;
        end
        if (stop_ev) begin
            ctrl_d.stop = 1'b0;
        end
        if (wr_set) begin
            ctrl_d.ack    = ctrl_d.ack    | bus.wdata[ACK_BIT];   // [R1] [R2]
            ctrl_d.iflag  = ctrl_d.iflag  | bus.wdata[IFLAG_BIT]; // [R1] [R2]
            ctrl_d.stop   = ctrl_d.stop   | bus.wdata[STOP_BIT];  // [R1] [R2]
            ctrl_d.start  = ctrl_d.start  | bus.wdata[START_BIT]; // [R1] [R2]
            ctrl_d.enable = ctrl_d.enable | bus.wdata[EN_BIT];    // [R1] [R2]
        end
        // applied last so a set write cannot sneak a stop past a disable
        if (!ctrl_d.enable) begin
            ctrl_d.stop = 1'b0; // [R5]
        end
    end

    // one flop bank for all control bits; set wins a tie with clear
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ctrl_q <= CTRL_RESET; // [R2]
        end else if (CLK_EN) begin
            ctrl_q <= ctrl_d;
        end
    end

    // ---------------------------------------------------------------
    // master sequencer
    // ---------------------------------------------------------------
    // a start request from idle or mid-transfer drives start; from master it
    // becomes a repeated start, since the state already holds master
    assign start_ev = ctrl_q.enable && ctrl_q.start &&
                      (state_q == ST_IDLE || state_q == ST_MASTER); // [R7]
    // a pending start outranks a stop, so the stop waits instead of being lost
    assign stop_ev  = ctrl_q.enable && ctrl_q.stop && !ctrl_q.start &&
                      state_q == ST_MASTER;

    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_q <= ST_IDLE;
        end else if (CLK_EN) begin
            if (!ctrl_q.enable) begin
                state_q <= ST_IDLE; // [R4] [R5]
            end else begin
                case (state_q)
                    ST_IDLE:   if (start_ev) state_q <= ST_START; // [R7]
                    ST_START:  state_q <= ST_MASTER;
                    ST_MASTER: begin
                        if (start_ev) begin
                            state_q <= ST_START; // [R7]
                        end else if (stop_ev) begin
                            state_q <= ST_STOP;
                        end
                    end
                    ST_STOP:   state_q <= ST_IDLE;
                    default:   state_q <= ST_IDLE;
                endcase
            end
        end
    end

    // ---------------------------------------------------------------
    // pin drive and status outputs
    // ---------------------------------------------------------------
    // active-low enables: sda pulled low during start, released otherwise
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            SDA_OE_N  <= 1'b1;
            SCL_OE_N  <= 1'b1;
            MASTER    <= 1'b0;
            ADDRESSED <= 1'b0;
        end else if (CLK_EN) begin
            SDA_OE_N  <= !(state_q == ST_START);
            SCL_OE_N  <= 1'b1;
            MASTER    <= ctrl_q.enable && state_q != ST_IDLE; // [R7]
            // slave addressing lives outside; disabled means never addressed
            if (!ctrl_q.enable || bus_stop) begin
                ADDRESSED <= 1'b0; // [R5]
            end else if (bus_start && state_q == ST_IDLE) begin
                ADDRESSED <= 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // interrupts
    // ---------------------------------------------------------------
    // sticky; a new event in the clear cycle survives
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            irq_stat_q <= IRQ_RESET;
            irq_en_q   <= IRQ_RESET;
        end else if (CLK_EN) begin
            if (bus.wr && bus.addr == IRQ_ENABLE_OFFS) begin
                irq_en_q <= bus.wdata[2:0];
            end
            irq_stat_q <= (irq_stat_q &
                           ~((bus.wr && bus.addr == IRQ_CLEAR_OFFS) ? bus.wdata[2:0] : 3'h0))
                          | {ctrl_q.iflag, stop_ev, start_ev};
        end
    end

    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            IRQ <= 1'b0;
        end else if (CLK_EN) begin
            IRQ <= |(irq_stat_q & irq_en_q);
        end
    end

    // ---------------------------------------------------------------
    // read port
    // ---------------------------------------------------------------
    // data valid only in the cycle after the strobe; reserved bits read zero
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            RDATA <= 32'h0000_0000;
        end else if (CLK_EN) begin
            RDATA <= 32'h0000_0000;
            if (bus.rd) begin
                case (bus.addr)
                    CONTROL_SET_OFFS: RDATA <= {25'h0, ctrl_q, 2'h0}; // [R8] [R3]
                    IRQ_STATUS_OFFS:  RDATA <= {29'h0, irq_stat_q};
                    IRQ_ENABLE_OFFS:  RDATA <= {29'h0, irq_en_q};
                    default:          RDATA <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule

// *** tb/i2ccs_properties.sv ***
`timescale 1ns/100ps
// ------------------------------
// control set port and data drive checker
// ------------------------------
module i2ccs_properties
    import i2ccs_pkg::*;
(
    input wire logic        REF_CLK,
    input wire logic        RESET_N,
    input wire logic        CLK_EN,
    input wire logic [31:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic        WR,
    input wire logic        RD,
    input wire logic [31:0] RDATA,
    input wire logic        SDA_OE_N,
    input wire logic        MASTER,
    input wire logic        ADDRESSED
);
    default clocking @(posedge REF_CLK);
    endclocking
    default disable iff (!RESET_N);
    // decoded control set accesses
    wire logic cs_rd = CLK_EN && RD && ADDR == CONTROL_SET_OFFS;
    wire logic cs_wr = CLK_EN && WR && ADDR == CONTROL_SET_OFFS;
    // idle read data is zero so slaves can be ORed on the bus
    a_rdata_idle: assert property (CLK_EN && !RD |=> RDATA == 32'h0000_0000)
        else $error("read data not idle");
    a_resv_zero: assert property (cs_rd |=> RDATA[31:7] == 25'h000_0000)
        else $error("reserved bits set");
    a_set_sticks: assert property (
        cs_wr && WDATA[EN_BIT] ##1 !WR ##1 cs_rd |=> RDATA[EN_BIT])
        else $error("written one not set");
    a_off_unaddr: assert property (cs_rd ##1 !RDATA[EN_BIT] |-> !ADDRESSED && !MASTER)
        else $error("active while disabled");
    a_stop_forced: assert property (cs_rd ##1 !RDATA[EN_BIT] |-> !RDATA[STOP_BIT])
        else $error("stop set while disabled");
    a_start_drive: assert property (
        cs_wr && WDATA[START_BIT] && WDATA[EN_BIT] |-> ##[1:4] !SDA_OE_N) else $error("no start");
    a_drive_pulse: assert property (CLK_EN && !SDA_OE_N |=> SDA_OE_N)
        else $error("data held low");
    a_drive_master: assert property ($fell(SDA_OE_N) |-> ##[0:1] MASTER)
        else $error("start without master");
endmodule
bind i2ccs_top i2ccs_properties i2ccs_properties_i (
    .REF_CLK   (REF_CLK),
    .RESET_N   (RESET_N),
    .CLK_EN    (CLK_EN),
    .ADDR      (ADDR),
    .WDATA     (WDATA),
    .WR        (WR),
    .RD        (RD),
    .RDATA     (RDATA),
    .SDA_OE_N  (SDA_OE_N),
    .MASTER    (MASTER),
    .ADDRESSED (ADDRESSED)
);

// *** tb/i2ccs_bus_model.sv ***
`timescale 1ns/100ps
// ------------------------------
// far-side bus device, open drain
// ------------------------------
module i2ccs_bus_model (
    output logic scl = 1'b1,
    output logic sda = 1'b1
);
    // start: data falls while clock high; clock then parked low
    task automatic bus_start();
        sda = 1'b0;
        #62.5 scl = 1'b0;
    endtask
    // stop: data rises while clock high, lines released to pull-up
    task automatic bus_stop();
        #62.5 scl = 1'b1;
        #62.5 sda = 1'b1;
    endtask
endmodule

// *** tb/i2ccs_top_tb.sv ***
`timescale 1ns/100ps
module i2ccs_top_tb;
    import i2ccs_pkg::*;
    logic        REF_CLK, RESET_N = 1'b0, WR = 1'b0, RD = 1'b0, CLK_EN = 1'b1;
    logic [31:0] ADDR = 32'h0000_0000, WDATA = 32'h0000_0000, RDATA;
    logic        SCL_OE_N, SDA_OE_N, MASTER, ADDRESSED, IRQ, scl_m, sda_m;
    int          miscompares = 0, n_compared = 0, cycles = 0;
    // wired-and lines: either party may pull low
    wire logic   scl_line = scl_m & SCL_OE_N;
    wire logic   sda_line = sda_m & SDA_OE_N;
    i2ccs_top i2ccs_top_i (
        .REF_CLK   (REF_CLK),
        .RESET_N   (RESET_N),
        .CLK_EN    (CLK_EN),
        .ADDR      (ADDR),
        .WDATA     (WDATA),
        .WR        (WR),
        .RD        (RD),
        .RDATA     (RDATA),
        .SCL_IN    (scl_line),
        .SDA_IN    (sda_line),
        .SCL_OE_N  (SCL_OE_N),
        .SDA_OE_N  (SDA_OE_N),
        .MASTER    (MASTER),
        .ADDRESSED (ADDRESSED),
        .IRQ       (IRQ)
    );
    i2ccs_bus_model i2ccs_bus_model_i (.scl(scl_m), .sda(sda_m));
    // ------------------------------
    // clock, hang guard, access tasks
    // ------------------------------
    initial begin
        REF_CLK = 1'b0;
        forever #4 REF_CLK = ~REF_CLK;
    end
    // the sequence needs about 140 cycles; twenty times that means a hang
    always @(posedge REF_CLK) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            give_verdict();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge REF_CLK);
        WR <= 1'b1;
        ADDR <= a;
        WDATA <= d;
        @(posedge REF_CLK);
        WR <= 1'b0;
    endtask
    // read data only stand in the cycle after the strobe
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        @(posedge REF_CLK);
        RD <= 1'b1;
        ADDR <= a;
        @(posedge REF_CLK);
        RD <= 1'b0;
        #1 chk(RDATA, exp);
    endtask
    // the drive pulse is one cycle wide, so poll every cycle
    task automatic wait_drive();
        repeat (16) if (SDA_OE_N !== 1'b0) @(negedge REF_CLK);
        chk(SDA_OE_N, 1'b0);
        chk(MASTER, 1'b1);
        chk(SCL_OE_N, 1'b1);
    endtask
    task automatic give_verdict();
        if (miscompares == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ------------------------------
    // main sequence
    // ------------------------------
    initial begin
        repeat (4) @(posedge REF_CLK);
        RESET_N <= 1'b1;
        rd(CONTROL_SET_OFFS, 32'h0000_0000);
        rd(32'h400a_1ffc, 32'h0000_0000);
        wr(CONTROL_SET_OFFS, 32'h0000_0004);
        wr(CONTROL_SET_OFFS, 32'h0000_0000);
        rd(CONTROL_SET_OFFS, 32'h0000_0004);
        wr(CONTROL_SET_OFFS, 32'h0000_0010);
        rd(CONTROL_SET_OFFS, 32'h0000_0004);
        i2ccs_bus_model_i.bus_start();
        repeat (8) @(posedge REF_CLK);
        chk(ADDRESSED, 1'b0);
        i2ccs_bus_model_i.bus_stop();
        wr(CONTROL_SET_OFFS, 32'h0000_0040);
        rd(CONTROL_SET_OFFS, 32'h0000_0044);
        i2ccs_bus_model_i.bus_start();
        repeat (8) @(posedge REF_CLK);
        chk(ADDRESSED, 1'b1);
        // dropping enable loses bus state; release normally goes via ack
        wr(CONTROL_CLEAR_OFFS, 32'h0000_0040);
        rd(CONTROL_SET_OFFS, 32'h0000_0004);
        chk(ADDRESSED, 1'b0);
        i2ccs_bus_model_i.bus_stop();
        wr(CONTROL_SET_OFFS, 32'h0000_0060);
        wait_drive();
        rd(CONTROL_SET_OFFS, 32'h0000_006c);
        wr(CONTROL_CLEAR_OFFS, 32'h0000_0020);
        wr(CONTROL_SET_OFFS, 32'h0000_0020);
        wait_drive();
        wr(CONTROL_CLEAR_OFFS, 32'h0000_0020);
        wr(CONTROL_SET_OFFS, 32'h0000_0010);
        repeat (4) @(posedge REF_CLK);
        chk(MASTER, 1'b0);
        rd(CONTROL_SET_OFFS, 32'h0000_004c);
        // interrupt: sticky status, masked, enabled, then cleared
        rd(IRQ_STATUS_OFFS, 32'h0000_0007);
        chk(IRQ, 1'b0);
        wr(IRQ_ENABLE_OFFS, 32'h0000_0001);
        repeat (2) @(posedge REF_CLK);
        #1 chk(IRQ, 1'b1);
        wr(IRQ_CLEAR_OFFS, 32'h0000_0001);
        repeat (2) @(posedge REF_CLK);
        #1 chk(IRQ, 1'b0);
        rd(IRQ_STATUS_OFFS, 32'h0000_0006);
        // release through the ack flag, which keeps the bus state
        wr(CONTROL_CLEAR_OFFS, 32'h0000_000c);
        rd(CONTROL_SET_OFFS, 32'h0000_0040);
        wr(IRQ_CLEAR_OFFS, 32'h0000_0006);
        rd(IRQ_STATUS_OFFS, 32'h0000_0000);
        // a low clock enable must swallow a set write
        @(posedge REF_CLK) CLK_EN <= 1'b0;
        wr(CONTROL_SET_OFFS, 32'h0000_0004);
        CLK_EN <= 1'b1;
        rd(CONTROL_SET_OFFS, 32'h0000_0040);
        give_verdict();
    end
endmodule
